// file: hw/rth_core.sv
// Purpose: reset sequencing, reset causes and trap arbitration
// Assumes: core reports events on sys_clk_i, brown-out pin is async
// Notes:   one state struct, two comb blocks, one register block
`timescale 1ns/1ps
`default_nettype none
module rth_core
   import rth_pkg::*;
(
   input  wire logic          sys_clk_i,
   input  wire logic          rst_n_i,
   input  wire rth_avs_req_t  avs_req_i,
   output logic [31:0]        avs_readdata_o,
   output logic               avs_waitrequest_o,
   input  wire rth_core_evt_t core_evt_i,
   input  wire logic          bod_i,
   input  wire logic          vec_valid_i,
   input  wire logic [23:0]   vec_addr_i,
   output logic               core_rst_o,
   output logic               pc_redirect_o,
   output logic [23:0]        pc_target_o,
   output logic               vec_req_o,
   output logic [3:0]         vec_idx_o,
   output logic               div_abort_o,
   output logic [3:0]         cpu_priority_level_o,
   output logic               priority_level_msb_o,
   output logic               irq_block_all_o
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // vector outside program memory or not word aligned
   function automatic logic bad_vector(input logic [23:0] a);
      bad_vector = (a >= PROG_TOP) || a[0];
   endfunction : bad_vector

   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   rth_state_t st_q;
   rth_state_t st_d;
   logic       bod_s;
   logic       math_ovf31;
   logic       math_ovf39;
   logic       math_now;
   logic       vec_bad;
   logic [2:0] trap_cnt;
   logic       lockout;
   logic       ill_exec;
   logic       rst_req;
   logic       bus_req;
   logic       wr_go;
   logic [31:0] wmask;
   logic [CAUSE_W-1:0] cause_set;
   logic [CAUSE_W-1:0] cause_clr;

   // brown-out detector pin is asynchronous to the core clock
   rth_sync2 u_bod_sync (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .async_i   (bod_i),
      .sync_o    (bod_s)
   );

   // ------------------------------------------------------------
   // event decoding
   // ------------------------------------------------------------
   // overflow checks only count when software enabled them
   assign math_ovf31 = st_q.ctrl[CTRL_OVF31_EN]
                     & (|core_evt_i.acc_ovf31)
                     & ~core_evt_i.guard_used;
   assign math_ovf39 = st_q.ctrl[CTRL_OVF39_EN]
                     & (|core_evt_i.acc_ovf39)
                     & ~core_evt_i.sat_enabled;
   assign math_now   = core_evt_i.div_zero | math_ovf31 | math_ovf39
                     | core_evt_i.shift_excess;
   assign vec_bad    = (st_q.fsm == ST_VEC) & vec_valid_i
                     & bad_vector(vec_addr_i);
   // every distinct condition counts toward lockout
   assign trap_cnt   = 3'(core_evt_i.div_zero) + 3'(math_ovf31)
                     + 3'(math_ovf39) + 3'(core_evt_i.shift_excess)
                     + 3'(vec_bad);
   // a second bad vector while already handling one cannot recover
   assign lockout    = (st_q.fsm != ST_RESET)
                     & ((trap_cnt > 3'd1)
                     | (vec_bad & (st_q.lvl == LVL_ADDR)));
   // a flushed illegal opcode never reached execute
   assign ill_exec   = core_evt_i.illegal_op & ~core_evt_i.flush;
   // watchdog, uninit pointer, illegal, brown-out, lockout, reset op
   assign rst_req    = (st_q.fsm != ST_RESET)
                     & (core_evt_i.wdt_timeout | core_evt_i.uninit_w
                     | ill_exec | bod_s | lockout
                     | core_evt_i.sw_reset);

   // ------------------------------------------------------------
   // bus slave decode
   // ------------------------------------------------------------
   // one wait state: request is seen, answer stands on the next edge
   assign bus_req = avs_req_i.read | avs_req_i.write;
   assign wr_go   = avs_req_i.write & st_q.ack;
   assign wmask   = lane_mask(avs_req_i.byteenable);

   // sticky causes, software clears by writing ones
   always_comb begin
      cause_set          = '0;
      cause_set[C_WDT]   = rst_req & core_evt_i.wdt_timeout;
      cause_set[C_UNINW] = rst_req & core_evt_i.uninit_w;
      cause_set[C_ILL]   = rst_req & ill_exec;
      cause_set[C_BOR]   = rst_req & bod_s;
      cause_set[C_LOCK]  = lockout;
      cause_set[C_SWRST] = rst_req & core_evt_i.sw_reset;
      cause_set[C_MATH]  = (st_q.fsm != ST_RESET) & math_now;
      cause_set[C_ADDR]  = vec_bad;
      cause_clr = '0;
      if (wr_go && avs_req_i.address == REG_CAUSE) begin
         cause_clr = avs_req_i.writedata[CAUSE_W-1:0]
                   & wmask[CAUSE_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_d          = st_q;
      st_d.redirect = 1'b0;
      st_d.vec_req  = 1'b0;
      // set wins over a clear in the same cycle
      st_d.cause    = (st_q.cause & ~cause_clr) | cause_set;
      st_d.ack      = bus_req & ~st_q.ack;

      // read data captured in the wait cycle, unmapped reads zero
      if (bus_req && !st_q.ack) begin
         case (avs_req_i.address)
            REG_CAUSE: st_d.rdata = 32'(st_q.cause);
            REG_CTRL:  st_d.rdata = 32'(st_q.ctrl);
            REG_LEVEL: st_d.rdata = {20'h00000, st_q.fsm, st_q.depth,
                                     st_q.stk1 == 4'h0 ? st_q.stk0
                                                       : st_q.stk1,
                                     st_q.lvl};
            default:   st_d.rdata = 32'h00000000;
         endcase
      end

      if (wr_go && avs_req_i.address == REG_CTRL && avs_req_i.byteenable[0])
      begin
         st_d.ctrl = avs_req_i.writedata[1:0];
      end
      // software may move the level only outside traps, 0 to 7
      if (wr_go && avs_req_i.address == REG_LEVEL && avs_req_i.byteenable[0]
          && st_q.depth == 2'h0 && st_q.fsm == ST_RUN) begin
         st_d.lvl = {1'b0, avs_req_i.writedata[2:0]};
      end

      // math conditions wait until the instruction retires
      if (st_q.fsm != ST_RESET && math_now) begin
         st_d.pend_math = 1'b1;
      end

      case (st_q.fsm)
         ST_RESET: begin
            // core held in reset, no vector fetch involved
            st_d.lvl   = 4'h0;
            st_d.depth = 2'h0;
            st_d.pend_math = 1'b0;
            if (st_q.hold == 4'h0) begin
               // fetch restarts at zero; word zero jumps onward
               st_d.fsm      = ST_RUN;
               st_d.redirect = 1'b1;
               st_d.target   = RESET_PC;
            end else begin
               st_d.hold = st_q.hold - 4'h1;
            end
         end
         ST_RUN: begin
            // no mask is consulted, only the fixed level
            if ((st_q.pend_math || math_now)
                && core_evt_i.instr_done
                && LVL_MATH > st_q.lvl) begin
               st_d.stk1      = st_q.stk0;
               st_d.stk0      = st_q.lvl;
               st_d.depth     = st_q.depth + 2'h1;
               st_d.lvl       = LVL_MATH;
               st_d.pend_math = 1'b0;
               st_d.vec_req   = 1'b1;
               st_d.vec_idx   = LVL_MATH;
               st_d.fsm       = ST_VEC;
            end else if (core_evt_i.trap_return
                         && st_q.depth != 2'h0) begin
               st_d.lvl   = st_q.stk0;
               st_d.stk0  = st_q.stk1;
               st_d.stk1  = 4'h0;
               st_d.depth = st_q.depth - 2'h1;
            end
         end
         ST_VEC: begin
            if (vec_bad) begin
               // address error preempts the trap that fetched it
               st_d.stk1    = st_q.stk0;
               st_d.stk0    = st_q.lvl;
               st_d.depth   = st_q.depth + 2'h1;
               st_d.lvl     = LVL_ADDR;
               st_d.vec_req = 1'b1;
               st_d.vec_idx = LVL_ADDR;
            end else if (vec_valid_i) begin
               st_d.redirect = 1'b1;
               st_d.target   = vec_addr_i;
               st_d.fsm      = ST_RUN;
            end
         end
         default: st_d.fsm = ST_RESET;
      endcase

      // a reset outranks any trap work in progress
      if (rst_req) begin
         st_d.fsm       = ST_RESET;
         st_d.hold      = HOLD_LAST;
         st_d.lvl       = 4'h0;
         st_d.depth     = 2'h0;
         st_d.stk0      = 4'h0;
         st_d.stk1      = 4'h0;
         st_d.pend_math = 1'b0;
         st_d.vec_req   = 1'b0;
         st_d.redirect  = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign avs_readdata_o       = st_q.rdata;
   assign avs_waitrequest_o    = bus_req & ~st_q.ack;
   assign core_rst_o           = (st_q.fsm == ST_RESET);
   assign pc_redirect_o        = st_q.redirect;
   assign pc_target_o          = st_q.target;
   assign vec_req_o            = st_q.vec_req;
   assign vec_idx_o            = st_q.vec_idx;
   // abort must land in this cycle, before the divide iterates on
   assign div_abort_o          = (st_q.fsm != ST_RESET)
                               & core_evt_i.div_zero;
   assign cpu_priority_level_o = st_q.lvl;
   assign priority_level_msb_o = st_q.lvl[3];
   // interrupts run at levels 1 to 7 and are blocked at 7 or above
   assign irq_block_all_o      = (st_q.lvl >= LVL_IRQOFF);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   logic wr_cause;
   assign wr_cause = wr_go & (avs_req_i.address == REG_CAUSE);

   sequence s_rst_enter;
      $rose(core_rst_o);
   endsequence
   sequence s_rst_leave;
      $fell(core_rst_o) ##0 pc_redirect_o && pc_target_o == RESET_PC;
   endsequence

   a_reset_hold_len: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_rst_enter |-> core_rst_o [*8] ##1 core_rst_o [*2]
                      ##1 s_rst_leave)
      else $error("core reset not held then released to zero");

   a_watchdog_reset: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_q.fsm == ST_RUN && core_evt_i.wdt_timeout)
      |=> core_rst_o && st_q.cause[C_WDT])
      else $error("watchdog timeout did not reset");

   a_illegal_exec: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_q.fsm == ST_RUN && ill_exec) |=> core_rst_o && st_q.cause[C_ILL])
      else $error("executed illegal opcode did not reset");

   a_brownout_reset: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_q.fsm == ST_RUN && $rose(bod_i)) |-> ##[1:3] core_rst_o)
      else $error("brown-out did not reset in three cycles");

   a_lockout_reset: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_q.fsm != ST_RESET && core_evt_i.div_zero
       && core_evt_i.shift_excess)
      |=> core_rst_o && st_q.cause[C_LOCK] && !vec_req_o)
      else $error("simultaneous traps did not lock out");

   a_bad_vector_trap: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (vec_bad && !lockout && !rst_req)
      |=> vec_req_o && vec_idx_o == LVL_ADDR && !pc_redirect_o)
      else $error("bad vector did not raise address trap");

   a_trap_after_done: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (vec_req_o && vec_idx_o == LVL_MATH) |-> $past(core_evt_i.instr_done))
      else $error("math trap taken before instruction retired");

   a_trap_msb_set: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_q.depth != 2'h0) |-> priority_level_msb_o && irq_block_all_o)
      else $error("trap active without level msb");

   a_div_abort: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_q.fsm == ST_RUN && core_evt_i.div_zero && !rst_req)
      |-> div_abort_o ##1 st_q.pend_math || vec_req_o)
      else $error("divide by zero not aborted and trapped");

   a_cause_sticky: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !wr_cause |=> (st_q.cause & $past(st_q.cause)) == $past(st_q.cause))
      else $error("cause flag dropped without software clear");

   // reset never passes through vector fetch or a raised level
   a_reset_no_vector: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      core_rst_o |-> !vec_req_o && cpu_priority_level_o == 4'h0)
      else $error("vector fetch or level seen during reset");

   // level seven outside traps masks interrupts, not traps
   a_level7_blocks: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_q.depth == 2'h0 && st_q.lvl == LVL_IRQOFF)
      |-> irq_block_all_o && !priority_level_msb_o)
      else $error("level seven did not block interrupts");

   // a valid vector redirects fetch on the next cycle
   a_vector_redirect: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_q.fsm == ST_VEC && vec_valid_i && !vec_bad && !rst_req)
      |=> pc_redirect_o && pc_target_o == $past(vec_addr_i))
      else $error("valid vector did not redirect fetch");

endmodule : rth_core
`default_nettype wire

// file: hw/rth_pkg.sv
// Purpose: shared constants and types of the reset and trap handler
// Assumes: one 200 MHz core clock, Avalon-MM register access
// Notes:   offsets are byte addresses, one 32-bit word per register
//
// Behaviour
// - any reset reinitialises core state and restarts fetch at address zero
// - reset bypasses trap arbitration, no vector is fetched for it
// - word zero holds a jump; core executes it after the restart
// - six error sources can each force a full device reset
// - watchdog timeout forces a device reset
// - pointer use of a never-written working register forces a reset
// - executed illegal opcode resets; a flushed one raises nothing
// - synchronised brown-out detector signal forces a brown-out reset
// - several trap conditions in one cycle force a lockout reset
// - traps cannot be masked; each source has a fixed level
// - an invalid trap vector address raises the address error trap
// - a trap starts only after the offending instruction completes
// - trap levels are 8 to 15, so level msb is set in traps
// - level 7 outside traps blocks interrupts but traps still run
// - the address error trap may preempt a math trap during its vector fetch
// - divide by zero aborts the divide and takes the math trap
// - enabled bit 31 overflow without guard bits takes the math trap
// - enabled bit 39 overflow without saturation takes the math trap
// - an over-range shift amount takes the math trap
package rth_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [3:0] REG_CAUSE = 4'h0; // write one to clear
   localparam logic [3:0] REG_CTRL  = 4'h4; // math trap enables
   localparam logic [3:0] REG_LEVEL = 4'h8; // priority and nesting

   localparam int CTRL_OVF31_EN = 0;
   localparam int CTRL_OVF39_EN = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;

   // sticky cause bit positions
   localparam int C_POR   = 0;
   localparam int C_WDT   = 1;
   localparam int C_UNINW = 2;
   localparam int C_ILL   = 3;
   localparam int C_BOR   = 4;
   localparam int C_LOCK  = 5;
   localparam int C_SWRST = 6;
   localparam int C_MATH  = 7;
   localparam int C_ADDR  = 8;
   localparam int CAUSE_W = 9;
   localparam logic [CAUSE_W-1:0] CAUSE_RST = 9'h001;

   // ------------------------------------------------------------
   // trap levels, addresses and timing
   // ------------------------------------------------------------
   localparam logic [3:0]  LVL_MATH   = 4'hB;
   localparam logic [3:0]  LVL_ADDR   = 4'hD;
   localparam logic [3:0]  LVL_IRQOFF = 4'h7;
   localparam logic [23:0] RESET_PC   = 24'h000000;
   localparam logic [23:0] PROG_TOP   = 24'h004000; // first bad address

   localparam int CLK_PERIOD_PS = 5000;
   localparam int RST_HOLD_NS   = 50;   // least core reset pulse
   localparam int RST_HOLD_CYC  =
      (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [3:0] HOLD_LAST = 4'(RST_HOLD_CYC - 1);

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } rth_avs_req_t;

   typedef struct packed {
      logic       wdt_timeout;  // watchdog expired
      logic       uninit_w;     // unwritten register used as pointer
      logic       illegal_op;   // unused opcode reached execute
      logic       flush;        // that opcode is being flushed
      logic       sw_reset;     // reset instruction executed
      logic       div_zero;     // divide with zero divisor
      logic [1:0] acc_ovf31;    // per accumulator, overflow of bit 31
      logic [1:0] acc_ovf39;    // per accumulator, overflow of bit 39
      logic       guard_used;   // guard bits in use
      logic       sat_enabled;  // any saturation enabled
      logic       shift_excess; // shift amount out of range
      logic       instr_done;   // current instruction retires
      logic       trap_return;  // handler returns from trap
   } rth_core_evt_t;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_RUN   = 2'b01,
      ST_VEC   = 2'b10
   } rth_fsm_t;

   typedef struct packed {
      rth_fsm_t            fsm;
      logic [3:0]          hold;
      logic [CAUSE_W-1:0]  cause;
      logic [1:0]          ctrl;
      logic [3:0]          lvl;
      logic [3:0]          stk0;
      logic [3:0]          stk1;
      logic [1:0]          depth;
      logic                pend_math;
      logic                redirect;
      logic [23:0]         target;
      logic                vec_req;
      logic [3:0]          vec_idx;
      logic                ack;
      logic [31:0]         rdata;
   } rth_state_t;

   localparam rth_state_t STATE_RST = '{
      fsm: ST_RESET, hold: HOLD_LAST, cause: CAUSE_RST,
      ctrl: CTRL_RST, lvl: 4'h0, stk0: 4'h0, stk1: 4'h0,
      depth: 2'h0, pend_math: 1'b0, redirect: 1'b0,
      target: RESET_PC, vec_req: 1'b0, vec_idx: 4'h0,
      ack: 1'b0, rdata: 32'h00000000};

endpackage : rth_pkg

// file: hw/rth_sync2.sv
// Purpose: two-stage synchroniser for one asynchronous level
// Assumes: input changes slowly compared with the clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module rth_sync2 (
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_q;
   logic sync_q;

   // ------------------------------------------------------------
   // synchroniser chain
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule : rth_sync2
`default_nettype wire

// file: tb/rth_core_model.sv
// Purpose: core pipeline stand-in answering trap vector fetches
// Assumes: vec_req_i is a one-cycle registered pulse
// Notes:   bad_i makes the first vector of a trap invalid
`timescale 1ns/1ps
`default_nettype none
module rth_core_model
   import rth_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        vec_req_i,
   input  wire logic [3:0]  vec_idx_i,
   input  wire logic        bad_i,
   input  wire logic [23:0] addr_i,
   input  wire logic [2:0]  delay_i,
   output logic             vec_valid_o,
   output logic [23:0]      vec_addr_o
);
   // --------------------
   // vector fetch
   // --------------------
   // stall as told; word is scrambled once released, not held
   initial begin
      vec_valid_o = 1'b0;
      vec_addr_o  = 24'h000000;
      forever begin
         @(posedge sys_clk_i);
         if (vec_req_i === 1'b1) begin
            repeat (delay_i) @(posedge sys_clk_i);
            vec_valid_o <= 1'b1;
            vec_addr_o  <= (bad_i && vec_idx_i != LVL_ADDR) ?
                           PROG_TOP : addr_i;
            @(posedge sys_clk_i);
            vec_valid_o <= 1'b0;
            vec_addr_o  <= ~vec_addr_o;
         end
      end
   end
endmodule : rth_core_model
`default_nettype wire

// file: tb/rth_core_tb.sv
// Purpose: self-checking bench for the reset and trap handler
// Assumes: rth_core_model answers the vector fetches
// Notes:   redirects and vector requests are queued for the monitor
`timescale 1ns/1ps
`default_nettype none
module rth_core_tb;
   import rth_pkg::*;
   logic          sys_clk_i = 1'b0;
   logic          rst_n_i   = 1'b0;
   rth_avs_req_t  req       = '0;
   rth_core_evt_t evt       = '0;
   logic          bod       = 1'b0;
   logic          bad       = 1'b0;
   logic [23:0]   vaddr     = 24'h000100;
   logic [2:0]    dly       = 3'h0;
   logic          vvalid, vreq, rst_o, redir, abort, msb, blk, wait_o;
   logic [23:0]   vaddr_o, target;
   logic [31:0]   rdata, r;
   logic [3:0]    vidx, lvl;
   logic [27:0]   q[$];
   int            errors = 0;
   int            n_checks = 0;

   always #2.5 sys_clk_i = ~sys_clk_i;

   rth_core i_rth_core (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .avs_req_i(req), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
      .core_evt_i(evt), .bod_i(bod), .vec_valid_i(vvalid),
      .vec_addr_i(vaddr_o), .core_rst_o(rst_o), .pc_redirect_o(redir),
      .pc_target_o(target), .vec_req_o(vreq), .vec_idx_o(vidx),
      .div_abort_o(abort), .cpu_priority_level_o(lvl),
      .priority_level_msb_o(msb), .irq_block_all_o(blk));
   rth_core_model i_rth_core_model (.sys_clk_i(sys_clk_i),
      .vec_req_i(vreq), .vec_idx_i(vidx), .bad_i(bad), .addr_i(vaddr),
      .delay_i(dly), .vec_valid_o(vvalid), .vec_addr_o(vaddr_o));

   // --------------------
   // helpers
   // --------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp

   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   // request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
      req <= '{read: !w, write: w, address: a, byteenable: 4'hF,
               writedata: d};
      @(posedge sys_clk_i);
      // only the bench timeout ends a wait that never completes
      while (wait_o !== 1'b0) @(posedge sys_clk_i);
      rd = rdata;
      req <= '0;
      @(posedge sys_clk_i);
   endtask : bus

   task automatic ev(input rth_core_evt_t e);
      evt <= e;
      @(posedge sys_clk_i);
      evt <= '0;
      @(posedge sys_clk_i);
   endtask : ev

   // bounded wait until the monitor has seen every queued result
   task automatic wq;
      for (int n = 0; q.size() != 0; n++) begin
         if (n == 80) begin
            errors++;
            $display("unexpected %0t result missing", $time);
            q.delete();
         end else @(posedge sys_clk_i);
      end
   endtask : wq

   // one math trap, optionally through an invalid vector first
   task automatic trap(input rth_core_evt_t e, input logic b);
      rth_core_evt_t t = '0;
      logic [23:0]   a = 24'($urandom_range(0, 8191) * 2);
      t.trap_return = 1'b1;
      vaddr <= a;
      dly   <= 3'($urandom_range(0, 3));
      bad   <= b;
      q.push_back({4'h2, 20'h0, LVL_MATH});
      if (b) q.push_back({4'h2, 20'h0, LVL_ADDR});
      q.push_back({4'h1, a});
      ev(e);
      wq();
      repeat (b ? 2 : 1) ev(t);
   endtask : trap

   task automatic rst_src(input rth_core_evt_t e, input int c,
                          input logic b);
      bus(1'b1, REG_CAUSE, 32'h1FF, r);
      q.push_back({4'h1, RESET_PC});
      // brown-out pulse starts only after the causes were cleared
      bod <= b;
      ev(e);
      bod <= 1'b0;
      wq();
      bus(1'b0, REG_CAUSE, 32'h0, r);
      // lockout also records the math conditions behind it
      cmp(r, (32'(1) << c) | (32'(e.div_zero) << C_MATH));
   endtask : rst_src

   // --------------------
   // monitor
   // --------------------
   // oldest note is matched against each redirect or vector request
   always @(posedge sys_clk_i) begin
      if (evt.div_zero && rst_o === 1'b0) cmp({31'h0, abort}, 32'h1);
      if (redir === 1'b1 || vreq === 1'b1) begin
         if (q.size() == 0) begin
            errors++;
            $display("unexpected %0t result not expected", $time);
         end else if (vreq === 1'b1) begin
            cmp({4'h0, 4'h2, 20'h0, vidx}, {4'h0, q.pop_front()});
            cmp({27'h0, msb, lvl}, {27'h0, 1'b1, vidx});
         end else cmp({4'h0, 4'h1, target}, {4'h0, q.pop_front()});
      end
   end

   initial begin
      #100000;
      errors++;
      $display("unexpected %0t timeout", $time);
      stop_test();
   end

   // --------------------
   // tests
   // --------------------
   initial begin
      rth_core_evt_t e;
      void'($urandom(32'h58D1320E));
      q.push_back({4'h1, RESET_PC});
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      wq();
      bus(1'b0, REG_CAUSE, 32'h0, r);
      cmp(r, 32'h001);
      bus(1'b0, 4'hC, 32'h0, r);
      cmp(r, 32'h0);
      $display("test reset done");
      bus(1'b1, REG_CTRL, 32'h3, r);
      for (int k = 0; k < 4; k++) begin
         e = '0;
         e.instr_done   = 1'b1;
         e.div_zero     = (k == 0);
         e.acc_ovf31    = (k == 1) ? 2'b10 : 2'b00;
         e.acc_ovf39    = (k == 2) ? 2'b01 : 2'b00;
         e.shift_excess = (k == 3);
         trap(e, 1'b0);
      end
      e = '0;
      e.acc_ovf31  = 2'b01;
      e.guard_used = 1'b1;
      e.acc_ovf39   = 2'b10;
      e.sat_enabled = 1'b1;
      e.instr_done = 1'b1;
      ev(e);
      e = '0;
      e.illegal_op = 1'b1;
      e.flush      = 1'b1;
      ev(e);
      repeat (15) @(posedge sys_clk_i);
      cmp({31'h0, rst_o}, 32'h0);
      $display("test math done");
      bus(1'b1, REG_CAUSE, 32'h1FF, r);
      e = '0;
      e.div_zero   = 1'b1;
      e.instr_done = 1'b1;
      trap(e, 1'b1);
      bus(1'b0, REG_CAUSE, 32'h0, r);
      cmp(r, 32'h180);
      cmp({28'h0, lvl}, 32'h0);
      bus(1'b1, REG_LEVEL, 32'h7, r);
      cmp({27'h0, blk, lvl}, 32'h17);
      trap(e, 1'b0);
      cmp({28'h0, lvl}, 32'h7);
      $display("test nest done");
      for (int k = 0; k < 5; k++) begin
         e = '0;
         e.wdt_timeout  = (k == 0);
         e.uninit_w     = (k == 1);
         e.illegal_op   = (k == 2);
         e.sw_reset     = (k == 3);
         e.div_zero     = (k == 4);
         e.shift_excess = (k == 4);
         e.instr_done   = (k == 4);
         rst_src(e, k == 0 ? C_WDT : k == 1 ? C_UNINW : k == 2 ? C_ILL :
                 k == 3 ? C_SWRST : C_LOCK, 1'b0);
      end
      cmp({28'h0, lvl}, 32'h0);
      rst_src('0, C_BOR, 1'b1);
      $display("test resets done");
      stop_test();
   end
endmodule : rth_core_tb
`default_nettype wire
